// ---- rtl/srw_pkg.sv ----
// Purpose: Shared constants for the supervisory reset and watchdog block
// Assumes: 200 MHz internal clock
// Notes: Long counts are also top-level parameters so simulation can shorten them
package srw_pkg;
  localparam int CLK_HZ = 200000000;
  // Reset pulse period, in milliseconds
  localparam int RESET_PULSE_MS = 200;
  localparam longint RESET_PULSE_CYC_L = (longint'(CLK_HZ) * RESET_PULSE_MS + 999) / 1000;
  localparam int RESET_PULSE_CYC = int'(RESET_PULSE_CYC_L);
  // Watchdog timeout, in tenths of a second (1.6 s)
  localparam int WD_TIMEOUT_DS = 16;
  localparam longint WD_TIMEOUT_CYC_L = (longint'(CLK_HZ) * WD_TIMEOUT_DS) / 10;
  localparam int WD_TIMEOUT_CYC = int'(WD_TIMEOUT_CYC_L);
  // Debounce settle time for the manual reset input, in microseconds
  localparam int DEBOUNCE_US = 1000;
  localparam longint DEBOUNCE_CYC_L = (longint'(CLK_HZ) * DEBOUNCE_US) / 1000000;
  localparam int DEBOUNCE_CYC = int'(DEBOUNCE_CYC_L);
  localparam int CNT_W = 32;
  localparam int SYNC_STAGES = 2;
  // Kick pin decode
  typedef enum logic [2:0] {
    SRW_KICK_LOW = 3'h1,
    SRW_KICK_HIGH = 3'h2,
    SRW_KICK_FLOAT = 3'h4
  } srw_kick_t;
endpackage : srw_pkg

// ---- rtl/srw_sync_if.sv ----
// Purpose: Carries the synchronised inputs from the sync stage to the core
// Assumes: Single clock domain
// Notes: One producer, one consumer
`timescale 1ns/1ps
interface srw_sync_if;
  logic supply_low;
  logic fail_low;
  logic manual_n;
  logic kick_drv;
  logic kick_lvl;
  modport src (output supply_low, output fail_low, output manual_n, output kick_drv, output kick_lvl);
  modport dst (input supply_low, input fail_low, input manual_n, input kick_drv, input kick_lvl);
endinterface : srw_sync_if

// ---- rtl/srw_sync.sv ----
// Purpose: Two-flop synchroniser for one input bit
// Assumes: Input asynchronous to clk
// Notes: Only the second flop is visible outside
`timescale 1ns/1ps
module srw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Data
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : srw_sync

// ---- rtl/srw_supervisor.sv ----
// Purpose: Supervisory reset generator with watchdog and power-fail warning
// Assumes: Analog comparators outside; their results arrive as logic levels
// Notes: Kick pin arrives as drive-enable plus level, undriven means floating
//
// Overview of operation
// - Low manual reset input starts a system reset.
// - Manual reset input is debounced internally against switch bounce.
// - Undriven manual reset input reads high, requesting no reset.
// - Warning output low while power-fail sense is below reference.
// - Kick input decodes as high, low or floating.
// - Timeout output low once kick stays at one level past timeout.
// - Any kick edge, rising or falling, clears the watchdog counter.
// - Watchdog counter held cleared while system reset asserted.
// - Floating kick disables timeout; output low only for supply-low.
// - System reset held while supply-low indication is true.
// - Reset stretched for the pulse period after the last cause clears.
// - Watchdog timeout never asserts system reset by itself.
// - Timeout output stays low until a kick edge, a floating kick or reset clears it.
// - Timeout output forced low during any supply-low condition.
// - Timeout output returns high immediately when supply-low clears.
// - Active-high reset output is always the complement of active-low.
// - Watchdog timeout nominally 1.6 s; host must kick at least that often.
`timescale 1ns/1ps
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int RESET_CYC = RESET_PULSE_CYC,
  parameter int WD_CYC = WD_TIMEOUT_CYC,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Analog comparator results
  input wire logic supply_low,
  input wire logic fail_sense_in,
  // Manual reset pin, as level plus drive indication from the pad
  input wire logic manual_reset_request_n,
  input wire logic manual_reset_driven,
  // Watchdog kick pin, level plus drive indication
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_driven,
  // Outputs to the host
  output logic system_reset_n,
  output logic system_reset,
  output logic fail_warning_n,
  output logic watchdog_expired_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  srw_sync_if sif ();
  logic raw_manual_n;
  logic raw_kick_lvl;

  // Floating manual pin reads as pulled high; floating kick level reads low
  assign raw_manual_n = manual_reset_driven ? manual_reset_request_n : 1'b1;
  assign raw_kick_lvl = watchdog_kick_driven & watchdog_kick;

  // Supply-low resets high so the block powers up in reset
  srw_sync #(.RST_VAL(1'b1)) u_sync_vlow (.clk(clk), .rstn(rstn), .d(supply_low), .q(sif.supply_low));
  srw_sync #(.RST_VAL(1'b0)) u_sync_fail (.clk(clk), .rstn(rstn), .d(~fail_sense_in), .q(sif.fail_low));
  srw_sync #(.RST_VAL(1'b1)) u_sync_manual (.clk(clk), .rstn(rstn), .d(raw_manual_n), .q(sif.manual_n));
  srw_sync #(.RST_VAL(1'b0)) u_sync_kdrv (.clk(clk), .rstn(rstn), .d(watchdog_kick_driven), .q(sif.kick_drv));
  srw_sync #(.RST_VAL(1'b0)) u_sync_klvl (.clk(clk), .rstn(rstn), .d(raw_kick_lvl), .q(sif.kick_lvl));

  ////////////////////////////////////////////////////////////////////////////
  // Manual reset debounce

  // A low level asserts at once; release needs a stable high for DEB_CYC.
  // Trades a little release latency for immunity to contact bounce.
  logic manual_active;
  logic [CNT_W-1:0] deb_cnt;
  logic [CNT_W-1:0] next_deb_cnt;
  logic deb_done;

  assign deb_done = (deb_cnt >= CNT_W'(DEB_CYC));
  assign next_deb_cnt = !sif.manual_n ? '0 : (deb_done ? deb_cnt : deb_cnt + 1'b1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deb_cnt <= '0;
      manual_active <= 1'b0;
    end else begin
      deb_cnt <= next_deb_cnt;
      manual_active <= !sif.manual_n ? 1'b1 : (deb_done ? 1'b0 : manual_active);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  typedef enum logic [2:0] {
    SRW_ST_HOLD = 3'h1,
    SRW_ST_STRETCH = 3'h2,
    SRW_ST_RUN = 3'h4
  } srw_rst_st_t;

  srw_rst_st_t rst_st;
  srw_rst_st_t next_rst_st;
  logic [CNT_W-1:0] pulse_cnt;
  logic cause;
  logic pulse_done;
  logic next_in_reset;

  // Watchdog state never enters here
  assign cause = sif.supply_low | manual_active;
  assign pulse_done = (pulse_cnt >= CNT_W'(RESET_CYC - 1));

  always_comb begin
    next_rst_st = rst_st;
    case (rst_st)
      SRW_ST_HOLD: begin
        if (!cause) begin
          next_rst_st = SRW_ST_STRETCH;
        end
      end
      SRW_ST_STRETCH: begin
        if (cause) begin
          next_rst_st = SRW_ST_HOLD;
        end else if (pulse_done) begin
          next_rst_st = SRW_ST_RUN;
        end
      end
      SRW_ST_RUN: begin
        if (cause) begin
          next_rst_st = SRW_ST_HOLD;
        end
      end
      default: begin
        next_rst_st = SRW_ST_HOLD;
      end
    endcase
  end

  assign next_in_reset = (next_rst_st != SRW_ST_RUN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_st <= SRW_ST_HOLD;
      pulse_cnt <= '0;
    end else begin
      rst_st <= next_rst_st;
      pulse_cnt <= (rst_st == SRW_ST_STRETCH && !cause) ? pulse_cnt + 1'b1 : '0;
    end
  end

  // Both polarities come from one state so they can never disagree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_reset_n <= 1'b0;
      system_reset <= 1'b1;
    end else begin
      system_reset_n <= !next_in_reset;
      system_reset <= next_in_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-fail warning

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fail_warning_n <= 1'b1;
    end else begin
      fail_warning_n <= !sif.fail_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  srw_kick_t kick_st;
  srw_kick_t prev_kick;
  logic kick_edge;
  logic wd_en;
  logic [CNT_W-1:0] wd_cnt;
  logic wd_hit;
  logic wd_expired;

  assign kick_st = !sif.kick_drv ? SRW_KICK_FLOAT : (sif.kick_lvl ? SRW_KICK_HIGH : SRW_KICK_LOW);
  // Any change between driven levels counts, in either direction
  assign kick_edge = (kick_st != prev_kick) && (kick_st != SRW_KICK_FLOAT)
    && (prev_kick != SRW_KICK_FLOAT);
  assign wd_en = (kick_st != SRW_KICK_FLOAT);
  assign wd_hit = (wd_cnt >= CNT_W'(WD_CYC));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_kick <= SRW_KICK_FLOAT;
    end else begin
      prev_kick <= kick_st;
    end
  end

  // Limitation: a float-to-driven change restarts the count, it is not an edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt <= '0;
      wd_expired <= 1'b0;
    end else if (!system_reset_n || kick_edge || !wd_en) begin
      wd_cnt <= '0;
      wd_expired <= 1'b0;
    end else begin
      wd_cnt <= wd_hit ? wd_cnt : wd_cnt + 1'b1;
      wd_expired <= wd_expired | wd_hit;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_expired_n <= 1'b0;
    end else begin
      watchdog_expired_n <= !(sif.supply_low || wd_expired);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Cycles since the last reset cause; saturates so it never wraps back into range
  logic [CNT_W-1:0] quiet_cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_cnt <= '0;
    end else begin
      quiet_cnt <= cause ? '0 : (quiet_cnt[CNT_W-1] ? quiet_cnt : quiet_cnt + 1'b1);
    end
  end

  a_reset_complement: assert property (@(posedge clk) disable iff (!rstn)
    system_reset == !system_reset_n) else $error("reset outputs not complementary");

  a_supply_holds_reset: assert property (@(posedge clk) disable iff (!rstn)
    sif.supply_low |=> !system_reset_n) else $error("reset released during supply-low");

  a_manual_starts_reset: assert property (@(posedge clk) disable iff (!rstn)
    !sif.manual_n |-> ##2 !system_reset_n) else $error("manual reset did not assert reset");

  a_timeout_supply_low: assert property (@(posedge clk) disable iff (!rstn)
    sif.supply_low |=> !watchdog_expired_n) else $error("timeout output high in supply-low");

  a_timeout_release: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(sif.supply_low) && !wd_expired) |=> watchdog_expired_n)
    else $error("timeout output slow to release");

  a_warning_follows: assert property (@(posedge clk) disable iff (!rstn)
    sif.fail_low |=> !fail_warning_n) else $error("warning not low on power-fail");

  a_wd_held_reset: assert property (@(posedge clk) disable iff (!rstn)
    !system_reset_n |=> (wd_cnt == '0)) else $error("watchdog counting during reset");

  a_kick_clears: assert property (@(posedge clk) disable iff (!rstn)
    kick_edge |=> (wd_cnt == '0) && !wd_expired) else $error("kick edge did not clear watchdog");

  // The flag needs one cycle of float to clear, so the first float cycle is exempt
  a_float_disables: assert property (@(posedge clk) disable iff (!rstn)
    (!sif.kick_drv && !$past(sif.kick_drv) && !sif.supply_low) |=> watchdog_expired_n)
    else $error("timeout while kick floats");

  a_expired_sticks: assert property (@(posedge clk) disable iff (!rstn)
    (wd_expired && system_reset_n && !kick_edge && wd_en) |=> wd_expired)
    else $error("timeout cleared without a kick");

  a_wd_no_reset: assert property (@(posedge clk) disable iff (!rstn)
    (rst_st == SRW_ST_RUN && !cause) |=> system_reset_n) else $error("reset without a cause");

  a_stretch_len: assert property (@(posedge clk) disable iff (!rstn)
    (rst_st == SRW_ST_STRETCH && pulse_cnt == '0 && !cause) |-> ##1 !system_reset_n)
    else $error("reset released before pulse period");

  a_stretch_min: assert property (@(posedge clk) disable iff (!rstn)
    (!cause && quiet_cnt < CNT_W'(RESET_CYC)) |=> !system_reset_n)
    else $error("reset released before pulse period ended");

  a_stretch_max: assert property (@(posedge clk) disable iff (!rstn)
    (!cause && quiet_cnt == CNT_W'(RESET_CYC)) |=> system_reset_n)
    else $error("reset held past pulse period");

  a_timeout_sets: assert property (@(posedge clk) disable iff (!rstn)
    (wd_hit && system_reset_n && wd_en && !kick_edge) |=> wd_expired)
    else $error("watchdog count reached without timeout");

  a_expired_drives: assert property (@(posedge clk) disable iff (!rstn)
    wd_expired |=> !watchdog_expired_n) else $error("timeout output high after timeout");

  a_timeout_no_reset: assert property (@(posedge clk) disable iff (!rstn)
    (wd_expired && system_reset_n && !cause) |=> system_reset_n)
    else $error("watchdog timeout asserted reset");

  a_deb_holds: assert property (@(posedge clk) disable iff (!rstn)
    (manual_active && sif.manual_n && !deb_done) |=> manual_active)
    else $error("manual reset released before debounce");

  a_deb_release: assert property (@(posedge clk) disable iff (!rstn)
    (manual_active && sif.manual_n && deb_done) |=> !manual_active)
    else $error("manual reset not released after debounce");

  a_warning_release: assert property (@(posedge clk) disable iff (!rstn)
    !sif.fail_low |=> fail_warning_n) else $error("warning low without power-fail");

  a_kick_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $onehot(kick_st)) else $error("kick decode not one of three states");

  a_timeout_idle_high: assert property (@(posedge clk) disable iff (!rstn)
    (!sif.supply_low && !wd_expired) |=> watchdog_expired_n)
    else $error("timeout output low without a cause");

  a_float_no_edge: assert property (@(posedge clk) disable iff (!rstn)
    !sif.kick_drv |-> !kick_edge) else $error("kick edge seen while floating");

endmodule : srw_supervisor

// ---- testbench/srw_host_model.sv ----
// Purpose: Host side of the kick pin for the supervisor bench
// Assumes: Kick level changes only at the falling clock edge
// Notes: A floating pin shows a level that changes every cycle
`timescale 1ns/1ps
module srw_host_model (
  // Clock
  input wire logic clk,
  // Scenario control
  input wire logic kick_run,
  input wire logic kick_float,
  // Kick pin
  output logic watchdog_kick,
  output logic watchdog_kick_driven
);
  logic [3:0] tick = 4'h0;
  logic lvl = 1'b0;
  logic run_q = 1'b0;
  // Control taken on the rising edge so falling-edge bench writes never race the toggle
  always @(posedge clk) run_q <= kick_run;
  always @(negedge clk) begin
    tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
    // Toggle every 10 cycles, well inside the timeout
    if (run_q && tick == 4'h9) lvl <= ~lvl;
  end
  assign watchdog_kick_driven = ~kick_float;
  // A released pin must not look like a held level
  assign watchdog_kick = kick_float ? tick[0] : lvl;
endmodule : srw_host_model

// ---- testbench/test_srw_supervisor.sv ----
// Purpose: Self-checking bench for the supervisory reset and watchdog block
// Assumes: Shortened counts so the whole run is short
// Notes: Check points carry margins for the synchroniser latency
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %b seen %b", nm, e, g); end end
module test_srw_supervisor;
  import srw_pkg::*;
  localparam int RC = 20;
  localparam int WC = 50;
  localparam int DC = 5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_low = 1'b1;
  logic fail_sense_in = 1'b1;
  logic manual_n = 1'b1;
  logic manual_drv = 1'b1;
  logic kick_run = 1'b1;
  logic kick_float = 1'b0;
  logic kick, kick_drv, system_reset_n, system_reset, fail_warning_n, watchdog_expired_n;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #2.5 clk = ~clk;
  srw_supervisor #(.RESET_CYC(RC), .WD_CYC(WC), .DEB_CYC(DC)) i_srw_supervisor (
    .clk(clk), .rstn(rstn), .supply_low(supply_low), .fail_sense_in(fail_sense_in),
    .manual_reset_request_n(manual_n), .manual_reset_driven(manual_drv),
    .watchdog_kick(kick), .watchdog_kick_driven(kick_drv),
    .system_reset_n(system_reset_n), .system_reset(system_reset),
    .fail_warning_n(fail_warning_n), .watchdog_expired_n(watchdog_expired_n));
  srw_host_model i_srw_host_model (.clk(clk), .kick_run(kick_run), .kick_float(kick_float),
    .watchdog_kick(kick), .watchdog_kick_driven(kick_drv));
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  always @(negedge clk) `CHK("reset_pair", ~system_reset_n, system_reset)
  // Whole run needs about 660 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task t_power_up;
    cycles(10);
    `CHK("rst_n", 1'b0, system_reset_n)
    `CHK("wd_n", 1'b0, watchdog_expired_n)
    supply_low = 1'b0;
    cycles(5);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    cycles(RC - 10);
    `CHK("rst_n", 1'b0, system_reset_n)
    cycles(15);
    `CHK("rst_n", 1'b1, system_reset_n)
  endtask : t_power_up
  task t_fail;
    fail_sense_in = 1'b0;
    cycles(5);
    `CHK("fail_n", 1'b0, fail_warning_n)
    fail_sense_in = 1'b1;
    cycles(5);
    `CHK("fail_n", 1'b1, fail_warning_n)
  endtask : t_fail
  task t_manual;
    // Undriven pin with a wandering level must request nothing
    manual_drv = 1'b0;
    repeat (20) begin
      manual_n = ~manual_n;
      cycles(1);
    end
    `CHK("rst_n", 1'b1, system_reset_n)
    manual_drv = 1'b1;
    manual_n = 1'b0;
    cycles(5);
    `CHK("rst_n", 1'b0, system_reset_n)
    repeat (5) begin
      manual_n = ~manual_n;
      cycles(2);
      `CHK("rst_n", 1'b0, system_reset_n)
    end
    cycles(RC);
    `CHK("rst_n", 1'b0, system_reset_n)
    cycles(DC + 15);
    `CHK("rst_n", 1'b1, system_reset_n)
  endtask : t_manual
  task t_watchdog;
    kick_run = 1'b0;
    cycles(WC - 10);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    cycles(25);
    `CHK("wd_n", 1'b0, watchdog_expired_n)
    `CHK("rst_n", 1'b1, system_reset_n)
    cycles(30);
    `CHK("wd_n", 1'b0, watchdog_expired_n)
    kick_run = 1'b1;
    cycles(16);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    cycles(WC * 3);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
  endtask : t_watchdog
  task t_float;
    kick_float = 1'b1;
    cycles(WC * 3);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    kick_float = 1'b0;
    cycles(20);
  endtask : t_float
  task t_supply_dip;
    supply_low = 1'b1;
    cycles(5);
    `CHK("wd_n", 1'b0, watchdog_expired_n)
    `CHK("rst_n", 1'b0, system_reset_n)
    kick_run = 1'b0;
    cycles(30);
    `CHK("rst_n", 1'b0, system_reset_n)
    supply_low = 1'b0;
    cycles(5);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    `CHK("rst_n", 1'b0, system_reset_n)
    cycles(RC + 10);
    `CHK("rst_n", 1'b1, system_reset_n)
    // Kick held since the dip: only a counter held in reset stays clear
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    cycles(WC - 20);
    `CHK("wd_n", 1'b1, watchdog_expired_n)
    kick_run = 1'b1;
  endtask : t_supply_dip
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cycles(4);
    rstn = 1'b1;
    t_power_up;
    t_fail;
    t_manual;
    t_watchdog;
    t_float;
    t_supply_dip;
    print_verdict;
  end
endmodule : test_srw_supervisor
